// [rtl/scf_map.svh]
`ifndef SCF_MAP_SVH
`define SCF_MAP_SVH

// ==========================================================
// Configuration register
`define SCF_CFG_W 8
`define SCF_CFG_RST 8'h00
`define SCF_CNT_W 3

// ==========================================================
// Shared pin group: bit index of each function
`define SCF_PIN_OVR 0
`define SCF_PIN_SRC 1
`define SCF_PIN_SDI 2
`define SCF_PIN_SCK 3
`define SCF_PIN_SEL 4
`define SCF_PIN_W 5
`define SCF_OE_SERIAL 5'h01
`define SCF_OE_PARALLEL 5'h1F

// ==========================================================
// APB register offsets (byte addresses)
`define SCF_OFF_STATUS 8'h00
`define SCF_OFF_MASK 8'h04
`define SCF_OFF_CFG 8'h08
`define SCF_OFF_STATE 8'h0C

// ==========================================================
// Status and mask bit positions, reset values
`define SCF_EVT_W 3
`define SCF_EVT_OVERRUN 0
`define SCF_EVT_LOADED 1
`define SCF_EVT_FRAME 2
`define SCF_STATUS_RST 3'h0
`define SCF_MASK_RST 3'h0

`endif

// [rtl/scf_pkg.sv]
package scf_pkg;

  typedef enum logic [1:0]
  {
    SCF_RD_IDLE = 2'h0,
    SCF_RD_ACTIVE = 2'h1
  } scf_rd_type;

  // Outside-domain control levels after synchronisation
  typedef struct packed
  {
    logic port_sel_n;
    logic sclk;
    logic sdin;
    logic src_hw;
    logic edge_inv;
    logic ext_clk;
    logic ser_mode;
    logic sync_inv;
  } scf_pin_type;

  typedef struct packed
  {
    logic frame_start;
    logic cfg_loaded;
    logic overrun;
  } scf_evt_type;

endpackage

// [rtl/scf_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module scf_sync
#(
  parameter int W = 8
)
(
  input wire logic clk, // Block clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Filtered levels
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // ==========================================================
  // A change counts once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// [rtl/scf_top.sv]
// How it works
// - Frame sync brackets serial output when the device makes the read clock.
// - Invert input high at read start: frame sync low while data valid.
// - Invert input low at read start: frame sync high while data valid.
// - Parallel mode: error and config pins become output data bits 11 to 15.
// - Overrun flag works only in serial mode with external read clock.
// - Conversion ending during an unfinished read discards data, pulses flag.
// - Serial mode, source select low: settings from serial config register.
// - Source select high: settings from hardware config pins.
// - Config bits shift in MSB first into the config register.
// - Each config bit is captured on a config serial clock edge.
// - Edge invert input picks rising or falling config clock edge.
// - Config writes accepted only while port select asserted in software mode.
//
// Our own choices: the placing of the registers and the APB register port.
`include "scf_map.svh"
`timescale 1ns/10ps
`default_nettype none

module scf_top
  import scf_pkg::*;
(
  input wire logic clk, // 125 MHz block clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic irq, // Level interrupt
  input wire logic sync_polarity_invert, // Frame sync polarity pin
  input wire logic serial_parallel_select, // High selects serial mode
  input wire logic external_clock_select, // High selects host read clock
  input wire logic config_edge_invert, // High selects falling config edge
  input wire logic [4:0] pin_in, // Shared pins, input side
  output logic [4:0] pin_out, // Shared pins, output side
  output logic [4:0] pin_oe, // Shared pins, drive enable
  input wire logic [7:0] hw_cfg, // Hardware configuration pins
  input wire logic read_start, // Engine: serial read begins
  input wire logic read_end, // Engine: serial read completes
  input wire logic conv_done, // Engine: conversion completes
  input wire logic [4:0] par_hi, // Engine: parallel data bits 15..11
  output logic frame_sync, // Frame sync pin
  output logic result_discard, // Pulse: current result lost
  output logic [7:0] cfg_active // Settings in force
);

  // ==========================================================
  // Pin synchronisers
  scf_pin_type pin_s;
  logic [7:0] hw_cfg_s;

  scf_sync #(.W(8)) u_pin_sync
  (
    .clk(clk),
    .reset_n(reset_n),
    .d({pin_in[`SCF_PIN_SEL], pin_in[`SCF_PIN_SCK], pin_in[`SCF_PIN_SDI],
        pin_in[`SCF_PIN_SRC], config_edge_invert, external_clock_select,
        serial_parallel_select, sync_polarity_invert}),
    .q(pin_s)
  );

  scf_sync #(.W(`SCF_CFG_W)) u_cfg_sync
  (
    .clk(clk),
    .reset_n(reset_n),
    .d(hw_cfg),
    .q(hw_cfg_s)
  );

  logic slave_mode;
  logic sw_mode;
  assign slave_mode = pin_s.ser_mode & pin_s.ext_clk;
  assign sw_mode = pin_s.ser_mode & ~pin_s.src_hw;

  // ==========================================================
  // Read sequence and frame sync
  scf_rd_type rd_r;
  scf_rd_type rd_nxt;
  logic inv_r;
  logic inv_nxt;
  logic frame_r;
  logic frame_nxt;
  logic ovr_nxt;
  logic discard_r;
  scf_evt_type evt;

  always_comb
  begin
    rd_nxt = rd_r;
    ovr_nxt = 1'b0;
    // Polarity is frozen for the whole read so the frame cannot flip mid-word
    inv_nxt = (rd_r == SCF_RD_IDLE) ? pin_s.sync_inv : inv_r;
    unique case (rd_r)
      SCF_RD_IDLE:
      begin
        if (read_start && pin_s.ser_mode)
        begin
          rd_nxt = SCF_RD_ACTIVE;
        end
      end
      SCF_RD_ACTIVE:
      begin
        if (read_end)
        begin
          rd_nxt = SCF_RD_IDLE;
        end
        else if (conv_done && slave_mode)
        begin
          rd_nxt = SCF_RD_IDLE;
          ovr_nxt = 1'b1;
        end
      end
      default:
      begin
        rd_nxt = SCF_RD_IDLE;
      end
    endcase
    if (rd_nxt == SCF_RD_ACTIVE && !pin_s.ext_clk)
    begin
      frame_nxt = ~inv_nxt;
    end
    else
    begin
      frame_nxt = inv_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_r <= SCF_RD_IDLE;
      inv_r <= 1'b0;
      frame_r <= 1'b1;
      discard_r <= 1'b0;
    end
    else
    begin
      rd_r <= rd_nxt;
      inv_r <= inv_nxt;
      frame_r <= frame_nxt;
      discard_r <= ovr_nxt;
    end
  end

  // ==========================================================
  // Shared pins: serial error flag or parallel data bus
  logic [4:0] pout_r;
  logic [4:0] pout_nxt;
  logic [4:0] poe_r;
  logic [4:0] poe_nxt;

  always_comb
  begin
    if (pin_s.ser_mode)
    begin
      pout_nxt = {4'h0, ovr_nxt};
      poe_nxt = `SCF_OE_SERIAL;
    end
    else
    begin
      pout_nxt = par_hi;
      poe_nxt = `SCF_OE_PARALLEL;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pout_r <= '0;
      poe_r <= '0;
    end
    else
    begin
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
    end
  end

  // ==========================================================
  // Serial configuration port
  logic sck_prev_r;
  logic sck_rise;
  logic sck_fall;
  logic sck_edge;
  logic port_en;
  logic [`SCF_CFG_W-1:0] shift_r;
  logic [`SCF_CFG_W-1:0] shift_nxt;
  logic [`SCF_CFG_W-1:0] cfg_sw_r;
  logic [`SCF_CFG_W-1:0] cfg_sw_nxt;
  logic [`SCF_CNT_W-1:0] cnt_r;
  logic [`SCF_CNT_W-1:0] cnt_nxt;
  logic loaded_nxt;
  logic [`SCF_CFG_W-1:0] cfg_act_r;
  logic [`SCF_CFG_W-1:0] cfg_act_nxt;

  assign sck_rise = pin_s.sclk & ~sck_prev_r;
  assign sck_fall = ~pin_s.sclk & sck_prev_r;
  assign sck_edge = pin_s.edge_inv ? sck_fall : sck_rise;
  assign port_en = sw_mode & ~pin_s.port_sel_n;

  always_comb
  begin
    shift_nxt = shift_r;
    cfg_sw_nxt = cfg_sw_r;
    cnt_nxt = cnt_r;
    loaded_nxt = 1'b0;
    if (!port_en)
    begin
      cnt_nxt = '0;
    end
    else if (sck_edge)
    begin
      shift_nxt = {shift_r[`SCF_CFG_W-2:0], pin_s.sdin};
      if (cnt_r == `SCF_CNT_W'(`SCF_CFG_W - 1))
      begin
        cfg_sw_nxt = shift_nxt;
        cnt_nxt = '0;
        loaded_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + `SCF_CNT_W'(1);
      end
    end
    cfg_act_nxt = sw_mode ? cfg_sw_r : hw_cfg_s;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sck_prev_r <= 1'b0;
      shift_r <= `SCF_CFG_RST;
      cfg_sw_r <= `SCF_CFG_RST;
      cnt_r <= '0;
      cfg_act_r <= `SCF_CFG_RST;
    end
    else
    begin
      sck_prev_r <= pin_s.sclk;
      shift_r <= shift_nxt;
      cfg_sw_r <= cfg_sw_nxt;
      cnt_r <= cnt_nxt;
      cfg_act_r <= cfg_act_nxt;
    end
  end

  // ==========================================================
  // APB slave, status, mask and interrupt
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [`SCF_EVT_W-1:0] stat_r;
  logic [`SCF_EVT_W-1:0] stat_nxt;
  logic [`SCF_EVT_W-1:0] mask_r;
  logic [`SCF_EVT_W-1:0] mask_nxt;
  logic irq_r;
  logic irq_nxt;
  logic acc;
  logic fire;

  assign evt.overrun = ovr_nxt;
  assign evt.cfg_loaded = loaded_nxt;
  assign evt.frame_start = (rd_r == SCF_RD_IDLE) && (rd_nxt == SCF_RD_ACTIVE);
  assign acc = psel & penable & ~pready_r;
  assign fire = psel & penable & pready_r;

  always_comb
  begin
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (acc)
    begin
      prdata_nxt = '0;
      unique case (paddr)
        `SCF_OFF_STATUS: prdata_nxt = {29'h0, stat_r};
        `SCF_OFF_MASK: prdata_nxt = {29'h0, mask_r};
        `SCF_OFF_CFG: prdata_nxt = {23'h0, sw_mode, cfg_act_r};
        `SCF_OFF_STATE: prdata_nxt = {28'h0, rd_r == SCF_RD_ACTIVE, pin_s.ext_clk,
                                      pin_s.ser_mode, frame_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    if (fire && pwrite && paddr == `SCF_OFF_MASK)
    begin
      mask_nxt = pwdata[`SCF_EVT_W-1:0];
    end
    // Only bits that were returned are cleared, so a late event is not lost
    if (fire && !pwrite && paddr == `SCF_OFF_STATUS)
    begin
      stat_nxt = stat_r & ~prdata_r[`SCF_EVT_W-1:0];
    end
    stat_nxt = stat_nxt | evt;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      stat_r <= `SCF_STATUS_RST;
      mask_r <= `SCF_MASK_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign pin_out = pout_r;
  assign pin_oe = poe_r;
  assign frame_sync = frame_r;
  assign result_discard = discard_r;
  assign cfg_active = cfg_act_r;

  // ==========================================================
  // Assertions
  internal_frame_a: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(reset_n) && $past(pin_s.ext_clk)) |-> frame_r == $past(inv_nxt))
    else $error("frame sync active while host supplies the read clock");

  frame_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_r == SCF_RD_ACTIVE && $past(reset_n) && $past(rd_r) == SCF_RD_ACTIVE
     && !$past(pin_s.ext_clk) && $past(inv_r)) |-> !frame_r)
    else $error("inverted frame sync not low during read");

  frame_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_r == SCF_RD_ACTIVE && $past(reset_n) && $past(rd_r) == SCF_RD_ACTIVE
     && !$past(pin_s.ext_clk) && !$past(inv_r)) |-> frame_r)
    else $error("frame sync not high during read");

  // The release edge still registers reset values, so it cannot start an attempt
  parallel_bus_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_n && !pin_s.ser_mode)
    |=> (pin_oe == `SCF_OE_PARALLEL) && (pin_out == $past(par_hi)))
    else $error("shared pins not carrying parallel data bits");

  overrun_slave_a: assert property (@(posedge clk) disable iff (!reset_n)
    !slave_mode |=> !result_discard)
    else $error("overrun flagged outside serial slave mode");

  overrun_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_r == SCF_RD_ACTIVE && conv_done && !read_end && slave_mode)
    |=> result_discard && pin_out[`SCF_PIN_OVR] && rd_r == SCF_RD_IDLE
        ##1 !result_discard)
    else $error("overrun did not give one-cycle pulse");

  sw_config_a: assert property (@(posedge clk) disable iff (!reset_n)
    sw_mode |=> cfg_active == $past(cfg_sw_r))
    else $error("software settings not in force");

  hw_config_a: assert property (@(posedge clk) disable iff (!reset_n)
    !sw_mode |=> cfg_active == $past(hw_cfg_s))
    else $error("hardware settings not in force");

  msb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    (port_en && sck_edge && cnt_r == `SCF_CNT_W'(`SCF_CFG_W - 1))
    |=> cfg_sw_r == {$past(shift_r[`SCF_CFG_W-2:0]), $past(pin_s.sdin)})
    else $error("config word not loaded MSB first");

  edge_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
    (port_en && sck_edge) |=> shift_r[0] == $past(pin_s.sdin))
    else $error("config bit not captured on active edge");

  edge_select_a: assert property (@(posedge clk) disable iff (!reset_n)
    (port_en && (pin_s.edge_inv ? sck_rise : sck_fall))
    |=> shift_r == $past(shift_r) && cnt_r == $past(cnt_r))
    else $error("config shifted on the inactive edge");

  port_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    !port_en |=> cnt_r == '0 && cfg_sw_r == $past(cfg_sw_r))
    else $error("config written while port disabled");

endmodule

`default_nettype wire

// [testbench/scf_host.sv]
`timescale 1ns/10ps
`default_nettype none

module scf_host
(
  input wire logic clk, // Pacing clock
  input wire logic edge_inv, // High: device samples the falling edge
  output logic sck, // Config serial clock
  output logic sdi, // Config serial data
  output logic sel_n // Config port select, active low
);
  // ==========================================================
  // Idle levels
  initial
  begin
    sck = 1'b0;
    sdi = 1'b1;
    sel_n = 1'b1;
  end

  // ==========================================================
  // Writer: half period of 5 clk makes an 80 ns link clock
  task automatic send(input logic [7:0] word, input int nbits, input logic sel);
    begin
      sck <= edge_inv;
      repeat (8) @(posedge clk);
      sel_n <= ~sel;
      repeat (5) @(posedge clk);
      for (int i = 7; i > 7 - nbits; i--)
      begin
        sdi <= word[i];
        repeat (5) @(posedge clk);
        sck <= ~edge_inv;
        repeat (5) @(posedge clk);
        sck <= edge_inv;
      end
      repeat (5) @(posedge clk);
      sel_n <= 1'b1;
      // Released line shows the inverse, never a stale bit
      sdi <= ~sdi;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire

// [testbench/scf_top_bench.sv]
`include "scf_map.svh"
`timescale 1ns/10ps
`default_nettype none

module scf_top_bench;
  logic clk, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, hw_cfg = 8'h5A, cfg_active;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, irq, frame_sync, result_discard, rerr, sck, sdi, sel_n;
  logic inv = 1'b0, ser = 1'b1, ext = 1'b0, einv = 1'b0, src_hw = 1'b1;
  logic read_start = 1'b0, read_end = 1'b0, conv_done = 1'b0;
  logic [4:0] par_hi = 5'h00, pin_out, pin_oe, pin_in;
  int bad_count = 0, comparisons = 0, disc_n = 0, flag_n = 0;

  // Wire level of each shared pin: device drives where pin_oe is set, bench elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {sel_n, sck, sdi, src_hw, 1'b0});

  scf_top u_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .sync_polarity_invert(inv), .serial_parallel_select(ser),
    .external_clock_select(ext), .config_edge_invert(einv), .pin_in, .pin_out, .pin_oe,
    .hw_cfg, .read_start, .read_end, .conv_done, .par_hi, .frame_sync, .result_discard,
    .cfg_active);
  scf_host u_host (.clk, .edge_inv(einv), .sck, .sdi, .sel_n);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (result_discard === 1'b1)
      disc_n <= disc_n + 1;
    if (pin_out[0] === 1'b1 && ser === 1'b1)
      flag_n <= flag_n + 1;
  end

  // ==========================================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Engine strobe for one cycle: 0 read start, 1 conversion done, 2 read end
  task automatic pulse(input int k);
    read_start <= (k == 0);
    conv_done <= (k == 1);
    read_end <= (k == 2);
    @(posedge clk);
    read_start <= 1'b0;
    conv_done <= 1'b0;
    read_end <= 1'b0;
  endtask

  task automatic close_out();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // APB master; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    chk(32'(n), 32'h2, "access cycles");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp, "read data");
    chk(32'(rerr), 32'(err), "read error");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    xfer(1'b1, a, d);
    chk(32'(rerr), 32'(err), "write error");
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    step(5);
    chk(32'(frame_sync), 32'h1, "reset frame");
    chk(32'(pin_oe), 32'h0, "reset oe");
    reset_n <= 1'b1;
    step(10);
    rd(`SCF_OFF_STATUS, 32'h0, 1'b0);
    rd(`SCF_OFF_MASK, 32'h0, 1'b0);
    rd(`SCF_OFF_CFG, 32'h5A, 1'b0);
    rd(`SCF_OFF_STATE, 32'h2, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(8'h14, 32'h7, 1'b1);
    wr(`SCF_OFF_MASK, 32'hFFFF_FFFF, 1'b0);
    rd(`SCF_OFF_MASK, 32'h7, 1'b0);
    wr(`SCF_OFF_MASK, 32'h1, 1'b0);
    src_hw <= 1'b0;
    step(8);
    chk(32'(cfg_active), 32'h0, "software word at reset");
    u_host.send(8'hA5, 8, 1'b1);
    step(8);
    chk(32'(cfg_active), 32'hA5, "rising edge word");
    rd(`SCF_OFF_CFG, 32'h1A5, 1'b0);
    einv <= 1'b1;
    step(8);
    u_host.send(8'hF0, 4, 1'b1);
    u_host.send(8'h3C, 8, 1'b1);
    step(8);
    chk(32'(cfg_active), 32'h3C, "falling edge word");
    u_host.send(8'hFF, 8, 1'b0);
    step(8);
    chk(32'(cfg_active), 32'h3C, "deselected port");
    src_hw <= 1'b1;
    step(8);
    chk(32'(cfg_active), 32'h5A, "hardware pins again");
    rd(`SCF_OFF_STATUS, 32'h2, 1'b0);
    rd(`SCF_OFF_STATUS, 32'h0, 1'b0);
    // Internal read clock: both polarities, conversion end mid-read is harmless
    for (int p = 0; p < 2; p++)
    begin
      inv <= p[0];
      step(8);
      pulse(0);
      step(3);
      chk(32'(frame_sync), 32'(!p[0]), "frame active");
      pulse(1);
      step(3);
      chk(32'(frame_sync), 32'(!p[0]), "frame held");
      pulse(2);
      step(3);
      chk(32'(frame_sync), 32'(p[0]), "frame idle");
    end
    chk(32'(disc_n + flag_n), 32'h0, "no overrun in master mode");
    rd(`SCF_OFF_STATUS, 32'h4, 1'b0);
    inv <= 1'b0;
    ext <= 1'b1;
    step(8);
    pulse(0);
    step(2);
    chk(32'(frame_sync), 32'h0, "no frame with host clock");
    read_end <= 1'b1;
    conv_done <= 1'b1;
    step(1);
    read_end <= 1'b0;
    conv_done <= 1'b0;
    step(3);
    chk(32'(disc_n), 32'h0, "read done with conversion");
    chk(32'(irq), 32'h0, "irq quiet");
    pulse(0);
    step(2);
    pulse(1);
    step(4);
    chk(32'(disc_n), 32'h1, "result discarded");
    chk(32'(flag_n), 32'h1, "overrun flag pulse");
    chk(32'(irq), 32'h1, "irq on overrun");
    xfer(1'b0, `SCF_OFF_STATUS, 32'h0);
    chk(rdat & 32'h1, 32'h1, "overrun status");
    step(2);
    chk(32'(irq), 32'h0, "irq cleared");
    ser <= 1'b0;
    par_hi <= 5'h15;
    step(8);
    chk(32'(pin_oe), 32'h1F, "parallel drive");
    chk(32'(pin_out), 32'h15, "parallel bits");
    par_hi <= 5'h0A;
    step(2);
    chk(32'(pin_out), 32'h0A, "parallel bits follow");
    pulse(0);
    step(3);
    chk(32'(frame_sync), 32'h0, "no frame in parallel");
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule

`default_nettype wire
